// *** hw/asram_pkg.sv ***
// Constants for the asynchronous byte-wide memory host controller
package asram_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_PS = 5000;
    // Times in ns, fastest grade
    localparam int READ_CYCLE_NS = 12;
    localparam int ADDR_TO_VALID_NS = 12;
    localparam int OE_TO_VALID_NS = 6;
    localparam int WRITE_CYCLE_NS = 12;
    localparam int ADDR_SETUP_TO_STORE_END_NS = 10;
    localparam int STORE_PULSE_NS = 10;
    localparam int WRITE_DATA_SETUP_NS = 7;
    localparam int STROBE_TO_FLOAT_NS = 6;
    localparam int RETENTION_RECOVERY_NS = READ_CYCLE_NS;
    // Least times round up to whole cycles
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc
    localparam int READ_WAIT_CYC = ns_to_cyc(ADDR_TO_VALID_NS) + 1;
    localparam int STORE_FLOAT_CYC = ns_to_cyc(STROBE_TO_FLOAT_NS);
    localparam int STORE_LOW_CYC = ns_to_cyc(STORE_PULSE_NS + STROBE_TO_FLOAT_NS);
    localparam int RECOVERY_CYC = ns_to_cyc(RETENTION_RECOVERY_NS);
    localparam int CNT_W = 4;
endpackage : asram_pkg

// *** hw/asram_host.sv ***
// Host controller driving an asynchronous byte-wide static memory
// What this block does
// - Store happens while select and strobe low; strobe rises first to end it.
// - Write data stable 7 ns before store end, held 0 ns after.
// - Address stable 10 ns before store end; changes only outside store.
// - Strobe-controlled write with drive low lasts float delay plus data setup; here drive stays high and strobe low lasts store pulse plus float delay.
// - Host never drives data pins while device drives them.
// - Store strobe stays high for the whole read cycle.
// - Address valid at or before select falls in a read.
// - Deselect before supply drops for retention.
// - Wait one read cycle after retention before any access.
`timescale 1ns/1ps
`default_nettype none
module asram_host (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [asram_pkg::ADDR_W-1:0] req_addr,
    input wire logic [asram_pkg::DATA_W-1:0] req_wdata,
    output logic [asram_pkg::DATA_W-1:0] rsp_rdata,
    output logic rsp_valid,
    input wire logic retain_req,
    output logic retain_safe,
    output logic [asram_pkg::ADDR_W-1:0] addr_lines,
    output logic chip_select_n,
    output logic output_drive_n,
    output logic store_strobe_n,
    input wire logic [asram_pkg::DATA_W-1:0] data_pins_in,
    output logic [asram_pkg::DATA_W-1:0] data_pins_out,
    output logic data_pins_oe
);
    typedef enum logic [2:0] {
        ASRAM_IDLE = 3'b000,
        ASRAM_READ = 3'b001,
        ASRAM_WSET = 3'b010,
        ASRAM_WLOW = 3'b011,
        ASRAM_WEND = 3'b100,
        ASRAM_RETN = 3'b101,
        ASRAM_RECV = 3'b110
    } asram_state_t;

    logic rst_s1_reg, rst_n_reg;
    logic [asram_pkg::DATA_W-1:0] din_s1_reg, din_s2_reg;
    logic ret_s1_reg, ret_s2_reg;
    asram_state_t state_reg;
    logic [asram_pkg::CNT_W-1:0] cnt_reg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    // Pin inputs pass two flops; read data is sampled late to cover that
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            din_s1_reg <= 8'h00;
            din_s2_reg <= 8'h00;
            ret_s1_reg <= 1'b0;
            ret_s2_reg <= 1'b0;
        end else begin
            din_s1_reg <= data_pins_in;
            din_s2_reg <= din_s1_reg;
            ret_s1_reg <= retain_req;
            ret_s2_reg <= ret_s1_reg;
        end
    end

    // Held low until the reset copy lets go, or a request would be lost
    assign req_ready = rst_n_reg && (state_reg == ASRAM_IDLE) && !ret_s2_reg;
    assign retain_safe = (state_reg == ASRAM_RETN);

    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ASRAM_IDLE;
            cnt_reg <= 4'h0;
        end else begin
            case (state_reg)
                ASRAM_IDLE: begin
                    if (ret_s2_reg) begin
                        state_reg <= ASRAM_RETN;
                    end else if (req_valid) begin
                        state_reg <= req_write ? ASRAM_WSET : ASRAM_READ;
                        cnt_reg <= 4'h0;
                    end
                end
                ASRAM_READ: begin
                    // Two extra cycles cover the input synchroniser
                    if (cnt_reg == 4'(asram_pkg::READ_WAIT_CYC + 1)) begin
                        state_reg <= ASRAM_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                ASRAM_WSET: begin
                    state_reg <= ASRAM_WLOW;
                    cnt_reg <= 4'h0;
                end
                ASRAM_WLOW: begin
                    if (cnt_reg == 4'(asram_pkg::STORE_LOW_CYC - 1)) begin
                        state_reg <= ASRAM_WEND;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                ASRAM_WEND: begin
                    state_reg <= ASRAM_IDLE;
                end
                ASRAM_RETN: begin
                    if (!ret_s2_reg) begin
                        state_reg <= ASRAM_RECV;
                        cnt_reg <= 4'h0;
                    end
                end
                ASRAM_RECV: begin
                    if (cnt_reg == 4'(asram_pkg::RECOVERY_CYC - 1)) begin
                        state_reg <= ASRAM_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                default: state_reg <= ASRAM_IDLE;
            endcase
        end
    end

    // Pin drive: address and data held from request to end of cycle
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            addr_lines <= 19'h00000;
            data_pins_out <= 8'h00;
        end else if (state_reg == ASRAM_IDLE && req_valid && !ret_s2_reg) begin
            addr_lines <= req_addr;
            data_pins_out <= req_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            chip_select_n <= 1'b1;
            output_drive_n <= 1'b1;
            store_strobe_n <= 1'b1;
            data_pins_oe <= 1'b0;
        end else begin
            case (state_reg)
                ASRAM_IDLE: begin
                    // Select follows the address by one edge
                    chip_select_n <= 1'b1;
                    output_drive_n <= 1'b1;
                    store_strobe_n <= 1'b1;
                    data_pins_oe <= 1'b0;
                end
                ASRAM_READ: begin
                    chip_select_n <= 1'b0;
                    output_drive_n <= 1'b0;
                    store_strobe_n <= 1'b1;
                    data_pins_oe <= 1'b0;
                end
                ASRAM_WSET: begin
                    chip_select_n <= 1'b0;
                    output_drive_n <= 1'b1;
                    store_strobe_n <= 1'b0;
                    data_pins_oe <= 1'b0;
                end
                ASRAM_WLOW: begin
                    // Data only after the float delay, so no contention
                    chip_select_n <= 1'b0;
                    output_drive_n <= 1'b1;
                    store_strobe_n <= (cnt_reg == 4'(asram_pkg::STORE_LOW_CYC - 1));
                    data_pins_oe <= (cnt_reg >= 4'(asram_pkg::STORE_FLOAT_CYC - 1));
                end
                ASRAM_WEND: begin
                    // Strobe rose one edge ago; data and select were held that edge and drop here
                    chip_select_n <= 1'b1;
                    output_drive_n <= 1'b1;
                    store_strobe_n <= 1'b1;
                    data_pins_oe <= 1'b0;
                end
                default: begin
                    chip_select_n <= 1'b1;
                    output_drive_n <= 1'b1;
                    store_strobe_n <= 1'b1;
                    data_pins_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rsp_rdata <= 8'h00;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_reg == ASRAM_READ && cnt_reg == 4'(asram_pkg::READ_WAIT_CYC + 1)) begin
                rsp_rdata <= din_s2_reg;
                rsp_valid <= 1'b1;
            end
        end
    end

    store_while_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
        !output_drive_n |-> store_strobe_n) else $error("strobe low during read");
    no_contention_a: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
        data_pins_oe |-> output_drive_n) else $error("host drives during read");
    addr_stable_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
        (!store_strobe_n && $past(!store_strobe_n)) |-> $stable(addr_lines))
        else $error("address moved in store");
    sequence store_end_s;
        !store_strobe_n ##1 store_strobe_n;
    endsequence
    select_after_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
        store_end_s |-> !chip_select_n ##1 chip_select_n)
        else $error("select not held past store end");
    data_before_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
        store_end_s |-> $past(data_pins_oe, 2)) else $error("data setup short");
    read_response_a: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
        $fell(output_drive_n) |-> ##[1:8] rsp_valid) else $error("read never answered");
    recovery_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
        (state_reg == ASRAM_RETN ##1 state_reg == ASRAM_RECV) |-> (chip_select_n && !req_ready)[*3])
        else $error("access too soon after retention");
    retain_deselect_a: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
        retain_safe |-> chip_select_n) else $error("selected in retention");
endmodule : asram_host
`default_nettype wire

// *** bench/asram_dev_model.sv ***
// Behavioural model of the byte-wide static memory on the far side
`timescale 1ns/1ps
`default_nettype none
module asram_dev_model #(
    parameter int ACC_NS = 12,
    parameter int OE_NS = 6
) (
    input wire logic [asram_pkg::ADDR_W-1:0] addr_lines,
    input wire logic chip_select_n,
    input wire logic output_drive_n,
    input wire logic store_strobe_n,
    input wire logic [asram_pkg::DATA_W-1:0] pins,
    output logic [asram_pkg::DATA_W-1:0] dev_q,
    output logic dev_drv
);
    logic [asram_pkg::DATA_W-1:0] mem [0:(1<<asram_pkg::ADDR_W)-1];
    logic store_n;
    assign store_n = chip_select_n | store_strobe_n;
    // Whichever strobe rises first closes the store
    always @(posedge store_n) begin
        mem[addr_lines] <= pins;
    end
    // Drives only in the read decode; never while storing
    assign dev_drv = !chip_select_n && !output_drive_n && store_strobe_n;
    // Old byte held 3 ns, then garbage until access time
    always @(addr_lines or chip_select_n) begin
        dev_q <= #3 ~dev_q;
        dev_q <= #ACC_NS mem[addr_lines];
    end
    always @(negedge output_drive_n) begin
        dev_q <= #OE_NS mem[addr_lines];
    end
endmodule : asram_dev_model
`default_nettype wire

// *** bench/test_asram_host.sv ***
// Self-checking bench for the memory host controller
`timescale 1ns/1ps
`default_nettype none
module test_asram_host;
    localparam int N = 12;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic retain_req = 1'b0;
    logic [asram_pkg::ADDR_W-1:0] req_addr = '0;
    logic [asram_pkg::DATA_W-1:0] req_wdata = '0;
    logic req_ready, rsp_valid, retain_safe, chip_select_n, output_drive_n, store_strobe_n;
    logic data_pins_oe, dev_drv, cs_prev;
    logic [asram_pkg::ADDR_W-1:0] addr_lines, addr_prev;
    logic [asram_pkg::DATA_W-1:0] rsp_rdata, data_pins_out, data_pins_in, dev_q;
    logic [asram_pkg::DATA_W-1:0] bus_last = '0;
    logic [asram_pkg::DATA_W-1:0] exp_q [$];
    logic [asram_pkg::ADDR_W-1:0] a_tab [N];
    logic [asram_pkg::DATA_W-1:0] d_tab [N];
    logic [31:0] seed = 32'h682D3C15;
    int fail_count = 0;
    int cmp_count = 0;
    always #2.5 sys_clk = ~sys_clk;
    // No pull on the bus, so a floating line flips every cycle
    assign data_pins_in = data_pins_oe ? data_pins_out : (dev_drv ? dev_q : ~bus_last);
    asram_host uut (.sys_clk, .arst_n, .req_valid, .req_ready, .req_write, .req_addr,
        .req_wdata, .rsp_rdata, .rsp_valid, .retain_req, .retain_safe, .addr_lines,
        .chip_select_n, .output_drive_n, .store_strobe_n, .data_pins_in, .data_pins_out,
        .data_pins_oe);
    asram_dev_model dev (.addr_lines, .chip_select_n, .output_drive_n, .store_strobe_n,
        .pins(data_pins_in), .dev_q, .dev_drv);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic bound(input int n);
        if (n >= 100) begin
            fail_count++;
            final_report();
        end
    endtask : bound
    // Valid stays up between calls so requests run back to back
    task automatic do_req(input logic wr, input logic [18:0] a, input logic [7:0] d);
        int n;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge sys_clk);
        bound(n);
        @(posedge sys_clk);
        if (!wr) exp_q.push_back(d);
    endtask : do_req
    always @(posedge sys_clk) begin
        bus_last <= data_pins_in;
        addr_prev <= addr_lines;
        cs_prev <= chip_select_n;
        if (arst_n) begin
            check(data_pins_oe & dev_drv, 1'b0);
            if (!output_drive_n) check(store_strobe_n, 1'b1);
            if (!chip_select_n && !cs_prev) check(addr_lines, addr_prev);
            if (retain_safe === 1'b1) check(chip_select_n, 1'b1);
            if (rsp_valid === 1'b1) begin
                check(exp_q.size() > 0, 1'b1);
                if (exp_q.size() > 0) check(rsp_rdata, exp_q.pop_front());
            end
        end
    end
    initial begin
        int i, n;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        arst_n = 1'b1;
        for (i = 0; i < N; i++) begin
            seed = lfsr(seed);
            a_tab[i] = (i == 0) ? '0 : (i == 1) ? '1 : {seed[14:0], i[3:0]};
            d_tab[i] = seed[26:19];
        end
        for (i = 0; i < N; i++) do_req(1'b1, a_tab[i], d_tab[i]);
        // Reverse order puts a read right behind a write to the same place
        for (i = N - 1; i >= 0; i--) do_req(1'b0, a_tab[i], d_tab[i]);
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (n = 0; n < 100 && exp_q.size() > 0; n++) @(negedge sys_clk);
        bound(n);
        $display("test write and read back done");
        retain_req = 1'b1;
        for (n = 0; n < 100 && retain_safe !== 1'b1; n++) @(negedge sys_clk);
        bound(n);
        check(req_ready, 1'b0);
        retain_req = 1'b0;
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge sys_clk);
        bound(n);
        check(n >= asram_pkg::RECOVERY_CYC, 1'b1);
        do_req(1'b0, a_tab[2], d_tab[2]);
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (n = 0; n < 100 && exp_q.size() > 0; n++) @(negedge sys_clk);
        bound(n);
        $display("test retention done");
        final_report();
    end
endmodule : test_asram_host
`default_nettype wire
